/* hw/aot_power_ctrl.sv */
/*
  Always-on timekeeping and power mode controller: rc tick model with
  coarse trim, calibration divider, sleep timer, watchdog, reset cause
  and the active / idle / deep sleep / power down sequencer.
  Assumes a 10 MHz CLK, synchronous active-high RST from power-on,
  classic Wishbone access from the local processor only, and an
  asynchronous active-low wake pin from the host.
*/
`default_nettype none

module aot_power_ctrl
#(
  parameter int unsigned WDOG_TICKS = aot_pkg::WDOG_TIMEOUT_TICKS
)
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        HOST_WAKE_REQUEST_N,
  input  wire logic        CPU_IRQ_ANY,
  input  wire logic [7:0]  CORE_OUT_D,
  output logic      [7:0]  FROZEN_OUT_Q,
  output logic             CPU_HALT,
  output logic             CORE_POWER_EN,
  output logic             RADIO_POWER_EN,
  output logic             REGULATOR_OUTPUT_PIN,
  output logic             OUTPUT_FREEZE,
  output logic             RC_CLK_TICK,
  output logic             CAL_1K_TICK,
  output logic             CORE_RESET
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  aot_tmr_if tmr ();

  aot_pkg::aot_state_e state_r;
  aot_pkg::aot_state_e state_nxt;

  logic [10:0] rc_period_tbl [8];
  logic [10:0] rc_cnt_r;
  logic        rc_tick_r;
  logic [2:0]  trim_r;
  logic [7:0]  div_r;
  logic [7:0]  div_cnt_r;
  logic        cal_tick_r;
  logic [3:0]  presc_r;
  logic [15:0] target_r;
  logic [14:0] wd_cnt_r;
  logic        wd_fire;
  logic [2:0]  core_rst_cnt_r;
  logic        core_rst_r;
  logic [1:0]  cause_r;
  logic [1:0]  stat_r;
  logic [9:0]  settle_r;
  logic        wake_s1_r;
  logic        wake_s2_r;
  logic        wake_s3_r;
  logic        host_wake;
  logic        host_wake_edge;
  logic        sleeping;
  logic        ack_r;
  logic [31:0] dat_r;
  logic [31:0] rdata_nxt;
  logic        bus_req;
  logic        bus_wr;
  logic        cmd_wr;
  logic        wd_restart;
  logic [7:0]  div_eff;
  logic        pwr_on_r;
  logic        reg_en_r;
  logic        freeze_r;
  logic        halt_r;
  logic        freeze_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a write into a register image
  function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  // register hit on the word address
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign bus_req    = WB_CYC_I && WB_STB_I && !ack_r;
  assign bus_wr     = bus_req && WB_WE_I;
  assign cmd_wr     = bus_wr && hit(WB_ADR_I, aot_pkg::ADR_POWER_CMD) && WB_SEL_I[0];
  // only the local processor sits on this bus, the host has no way in
  assign wd_restart = bus_wr && hit(WB_ADR_I, aot_pkg::ADR_WDOG_RESTART);

  // one wait state answer, ack drops the cycle after it was given
  always_ff @(posedge CLK)
  begin
    if (RST)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req;
  end

  // read mux, unmapped words read zero and ignore writes
  always_comb
  begin
    rdata_nxt = 32'h0;
    if (hit(WB_ADR_I, aot_pkg::ADR_RC_TRIM))
      rdata_nxt = 32'(trim_r);
    else if (hit(WB_ADR_I, aot_pkg::ADR_CAL_DIV))
      rdata_nxt = 32'(div_r);
    else if (hit(WB_ADR_I, aot_pkg::ADR_PRESCALE))
      rdata_nxt = 32'(presc_r);
    else if (hit(WB_ADR_I, aot_pkg::ADR_SLEEP_COUNT))
      rdata_nxt = 32'(tmr.count);
    else if (hit(WB_ADR_I, aot_pkg::ADR_WAKE_TARGET))
      rdata_nxt = 32'(target_r);
    else if (hit(WB_ADR_I, aot_pkg::ADR_POWER_CMD))
      rdata_nxt = 32'(state_r);
    else if (hit(WB_ADR_I, aot_pkg::ADR_WDOG_RESTART))
      rdata_nxt = 32'(wd_cnt_r);
    else if (hit(WB_ADR_I, aot_pkg::ADR_RESET_CAUSE))
      rdata_nxt = 32'(cause_r);
    else if (hit(WB_ADR_I, aot_pkg::ADR_STATUS))
      rdata_nxt = 32'(stat_r);
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      dat_r <= 32'h0;
    else if (bus_req && !WB_WE_I)
      dat_r <= rdata_nxt;
  end

  // ----------------------------------------------------------------
  // always-on configuration registers
  // ----------------------------------------------------------------
  // kept across sleep and across watchdog resets, only RST clears them
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      trim_r   <= aot_pkg::TRIM_RST;
      div_r    <= aot_pkg::DIV_RST;
      presc_r  <= aot_pkg::PRESC_RST;
      target_r <= aot_pkg::TARGET_RST;
    end
    else if (bus_wr)
    begin
      if (hit(WB_ADR_I, aot_pkg::ADR_RC_TRIM))
        trim_r <= 3'(merge32(32'(trim_r), WB_DAT_I, WB_SEL_I));
      if (hit(WB_ADR_I, aot_pkg::ADR_CAL_DIV))
        div_r <= 8'(merge32(32'(div_r), WB_DAT_I, WB_SEL_I));
      if (hit(WB_ADR_I, aot_pkg::ADR_PRESCALE))
        presc_r <= 4'(merge32(32'(presc_r), WB_DAT_I, WB_SEL_I));
      if (hit(WB_ADR_I, aot_pkg::ADR_WAKE_TARGET))
        target_r <= 16'(merge32(32'(target_r), WB_DAT_I, WB_SEL_I));
    end
  end

  // ----------------------------------------------------------------
  // rc oscillator model and calibration divider
  // ----------------------------------------------------------------
  // trim code is signed, each step shifts the rate by one kilohertz
  for (genvar g = 0; g < 8; g++)
  begin : g_rc_tbl
    assign rc_period_tbl[g] = 11'(aot_pkg::rc_period((g < 4) ? g : g - 8));
  end

  // free running in every state, nothing here looks at the power mode
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rc_cnt_r  <= 11'h0;
      rc_tick_r <= 1'b0;
    end
    else
    begin
      rc_tick_r <= (rc_cnt_r >= rc_period_tbl[trim_r] - 11'h1);
      rc_cnt_r  <= (rc_cnt_r >= rc_period_tbl[trim_r] - 11'h1) ? 11'h0 : rc_cnt_r + 11'h1;
    end
  end

  // zero would mean no division at all, treat it as one
  assign div_eff = (div_r == 8'h0) ? 8'h1 : div_r;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      div_cnt_r  <= 8'h0;
      cal_tick_r <= 1'b0;
    end
    else
    begin
      cal_tick_r <= rc_tick_r && (div_cnt_r >= div_eff - 8'h1);
      if (rc_tick_r)
        div_cnt_r <= (div_cnt_r >= div_eff - 8'h1) ? 8'h0 : div_cnt_r + 8'h1;
    end
  end

  assign RC_CLK_TICK = rc_tick_r;
  assign CAL_1K_TICK = cal_tick_r;

  // ----------------------------------------------------------------
  // sleep timer
  // ----------------------------------------------------------------
  assign tmr.cal_tick  = cal_tick_r;
  assign tmr.presc_exp = presc_r;
  assign tmr.target    = target_r;

  aot_sleep_timer u_sleep_timer
  (
    .clk (CLK),
    .rst (RST),
    .tmr (tmr.timer)
  );

  // ----------------------------------------------------------------
  // watchdog and core reset
  // ----------------------------------------------------------------
  // held still in deep sleep and power down, a restart write still clears it then
  assign wd_fire = rc_tick_r && !sleeping && (wd_cnt_r >= 15'(WDOG_TICKS - 1));

  always_ff @(posedge CLK)
  begin
    if (RST || wd_restart || wd_fire)
      wd_cnt_r <= 15'h0;
    else if (rc_tick_r && !sleeping)
      wd_cnt_r <= wd_cnt_r + 15'h1;
  end

  // internal core reset only, it has no path to any host-facing pin
  always_ff @(posedge CLK)
  begin
    if (RST || wd_fire)
      core_rst_cnt_r <= 3'(aot_pkg::CORE_RST_CYC);
    else if (core_rst_cnt_r != 3'h0)
      core_rst_cnt_r <= core_rst_cnt_r - 3'h1;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      core_rst_r <= 1'b1;
    else
      core_rst_r <= wd_fire || (core_rst_cnt_r > 3'h1);
  end

  assign CORE_RESET = core_rst_r;

  // last cause wins, write one clears, a new cause beats the clear
  always_ff @(posedge CLK)
  begin
    if (RST)
      cause_r <= aot_pkg::CAUSE_RST;
    else if (wd_fire)
      cause_r <= 2'(1 << aot_pkg::CAUSE_WDOG_BIT);
    else if (bus_wr && hit(WB_ADR_I, aot_pkg::ADR_RESET_CAUSE) && WB_SEL_I[0])
      cause_r <= cause_r & ~WB_DAT_I[1:0];
  end

  // ----------------------------------------------------------------
  // host wake input
  // ----------------------------------------------------------------
  // asynchronous pin, two flops before use
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wake_s1_r <= 1'b1;
      wake_s2_r <= 1'b1;
      wake_s3_r <= 1'b1;
    end
    else
    begin
      wake_s1_r <= HOST_WAKE_REQUEST_N;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
    end
  end

  assign host_wake      = !wake_s2_r;
  assign host_wake_edge = wake_s3_r && !wake_s2_r;

  // sticky events, a set in the clearing cycle survives
  always_ff @(posedge CLK)
  begin
    if (RST)
      stat_r <= 2'h0;
    else
    begin
      stat_r[aot_pkg::STAT_MATCH_BIT] <= tmr.match || (stat_r[aot_pkg::STAT_MATCH_BIT] &&
        !(bus_wr && hit(WB_ADR_I, aot_pkg::ADR_STATUS) && WB_SEL_I[0] && WB_DAT_I[aot_pkg::STAT_MATCH_BIT]));
      stat_r[aot_pkg::STAT_WAKE_BIT] <= host_wake_edge || (stat_r[aot_pkg::STAT_WAKE_BIT] &&
        !(bus_wr && hit(WB_ADR_I, aot_pkg::ADR_STATUS) && WB_SEL_I[0] && WB_DAT_I[aot_pkg::STAT_WAKE_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // power state sequencer
  // ----------------------------------------------------------------
  assign sleeping = (state_r == aot_pkg::AOT_DEEP) || (state_r == aot_pkg::AOT_PDOWN);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      aot_pkg::AOT_ACTIVE:
        if (cmd_wr)
          case (WB_DAT_I[1:0])
            aot_pkg::CMD_IDLE:  state_nxt = aot_pkg::AOT_IDLE;
            aot_pkg::CMD_DEEP:  state_nxt = aot_pkg::AOT_DEEP;
            aot_pkg::CMD_PDOWN: state_nxt = aot_pkg::AOT_PDOWN;
            default:            state_nxt = aot_pkg::AOT_ACTIVE;
          endcase
      aot_pkg::AOT_IDLE:
        if (CPU_IRQ_ANY || host_wake)
          state_nxt = aot_pkg::AOT_ACTIVE;
      aot_pkg::AOT_DEEP:
        if (tmr.match || host_wake)
          state_nxt = aot_pkg::AOT_WAKE;
      aot_pkg::AOT_PDOWN:
        if (host_wake)
          state_nxt = aot_pkg::AOT_WAKE;
      aot_pkg::AOT_WAKE:
        if (settle_r >= 10'(aot_pkg::REG_SETTLE_CYC - 1))
          state_nxt = aot_pkg::AOT_ACTIVE;
      default:
        state_nxt = aot_pkg::AOT_ACTIVE;
    endcase
    // chip reset overrides, so the power outputs follow the state at once
    if (wd_fire)
      state_nxt = aot_pkg::AOT_ACTIVE;
  end

  // a watchdog expiry is a chip reset, it lands the core back in active
  always_ff @(posedge CLK)
  begin
    if (RST || wd_fire)
      state_r <= aot_pkg::AOT_ACTIVE;
    else
      state_r <= state_nxt;
  end

  // regulator settling time before the core is powered again
  always_ff @(posedge CLK)
  begin
    if (RST || state_r != aot_pkg::AOT_WAKE)
      settle_r <= 10'h0;
    else
      settle_r <= settle_r + 10'h1;
  end

  // ----------------------------------------------------------------
  // power controls and frozen outputs
  // ----------------------------------------------------------------
  assign freeze_nxt = (state_nxt == aot_pkg::AOT_DEEP) || (state_nxt == aot_pkg::AOT_PDOWN) ||
                      (state_nxt == aot_pkg::AOT_WAKE);

  // idle keeps every domain, radio included, powered and clocked
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pwr_on_r <= 1'b1;
      reg_en_r <= 1'b1;
      freeze_r <= 1'b0;
      halt_r   <= 1'b0;
    end
    else
    begin
      pwr_on_r <= !freeze_nxt;
      reg_en_r <= (state_nxt != aot_pkg::AOT_DEEP) && (state_nxt != aot_pkg::AOT_PDOWN);
      freeze_r <= freeze_nxt;
      halt_r   <= state_nxt != aot_pkg::AOT_ACTIVE;
    end
  end

  // captured up to the cycle before entry, then held until active again
  always_ff @(posedge CLK)
  begin
    if (RST)
      FROZEN_OUT_Q <= 8'h00;
    else if (!freeze_nxt)
      FROZEN_OUT_Q <= CORE_OUT_D;
  end

  assign CORE_POWER_EN        = pwr_on_r;
  assign RADIO_POWER_EN       = pwr_on_r;
  assign REGULATOR_OUTPUT_PIN = reg_en_r;
  assign OUTPUT_FREEZE        = freeze_r;
  assign CPU_HALT             = halt_r;
  assign WB_ACK_O             = ack_r;
  assign WB_DAT_O             = dat_r;

endmodule

`default_nettype wire

/* hw/aot_sleep_timer.sv */
/*
  Sleep timer: power-of-two prescaler on the calibrated tick and a
  free-running 16-bit millisecond counter with a compare match.
  Assumes cal_tick is a one-cycle pulse on the same clock.
*/
`default_nettype none

module aot_sleep_timer
(
  input  wire logic clk,
  input  wire logic rst,
  aot_tmr_if.timer  tmr
);

  logic [15:0] pre_r;
  logic [15:0] cnt_r;
  logic        match_r;
  logic [15:0] pre_last;
  logic        ms_tick;
  logic [15:0] cnt_nxt;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // >= so a smaller exponent written mid-count cannot stall a full wrap
  assign pre_last = 16'((17'h1 << tmr.presc_exp) - 17'h1);
  assign ms_tick  = tmr.cal_tick && (pre_r >= pre_last);
  assign cnt_nxt  = cnt_r + 16'h1;

  always_ff @(posedge clk)
  begin
    if (rst)
      pre_r <= 16'h0;
    else if (tmr.cal_tick)
      pre_r <= ms_tick ? 16'h0 : pre_r + 16'h1;
  end

  // ----------------------------------------------------------------
  // counter and match
  // ----------------------------------------------------------------
  // wraps silently at the top, software tracks the wraps
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= 16'h0;
    else if (ms_tick)
      cnt_r <= cnt_nxt;
  end

  // one-cycle pulse as the counter steps onto the target
  always_ff @(posedge clk)
  begin
    if (rst)
      match_r <= 1'b0;
    else
      match_r <= ms_tick && (cnt_nxt == tmr.target);
  end

  assign tmr.count = cnt_r;
  assign tmr.match = match_r;

endmodule

`default_nettype wire

/* pkg/aot_pkg.sv */
/*
  Shared constants for the always-on timer and power controller:
  clock rates, derived cycle counts, register offsets, field positions,
  reset values and the power state type.
  Assumes a 10 MHz system clock and a 32-bit classic Wishbone slave.
*/
`default_nettype none

package aot_pkg;

  // ----------------------------------------------------------------
  // clocks and times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned RC_NOM_HZ        = 10_000;
  localparam int unsigned RC_TRIM_STEP_HZ  = 1_000;
  localparam int unsigned CAL_HZ           = 1_000;
  localparam int unsigned WDOG_TIMEOUT_MS  = 2_000;
  localparam int unsigned WDOG_TIMEOUT_TICKS = WDOG_TIMEOUT_MS * (RC_NOM_HZ / 1_000);
  localparam int unsigned REG_SETTLE_NS    = 50_000;
  localparam int unsigned REG_SETTLE_CYC   = (REG_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned CORE_RST_CYC     = 4;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_RC_TRIM      = 8'h00;
  localparam logic [7:0] ADR_CAL_DIV      = 8'h04;
  localparam logic [7:0] ADR_PRESCALE     = 8'h08;
  localparam logic [7:0] ADR_SLEEP_COUNT  = 8'h0c;
  localparam logic [7:0] ADR_WAKE_TARGET  = 8'h10;
  localparam logic [7:0] ADR_POWER_CMD    = 8'h14;
  localparam logic [7:0] ADR_WDOG_RESTART = 8'h18;
  localparam logic [7:0] ADR_RESET_CAUSE  = 8'h1c;
  localparam logic [7:0] ADR_STATUS       = 8'h20;

  // ----------------------------------------------------------------
  // fields, commands and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CAUSE_POR_BIT   = 0;
  localparam int unsigned CAUSE_WDOG_BIT  = 1;
  localparam int unsigned STAT_MATCH_BIT  = 0;
  localparam int unsigned STAT_WAKE_BIT   = 1;
  localparam logic [1:0]  CMD_IDLE        = 2'h1;
  localparam logic [1:0]  CMD_DEEP        = 2'h2;
  localparam logic [1:0]  CMD_PDOWN       = 2'h3;
  localparam logic [2:0]  TRIM_RST        = 3'h0;
  localparam logic [7:0]  DIV_RST         = 8'(RC_NOM_HZ / CAL_HZ);
  localparam logic [3:0]  PRESC_RST       = 4'h0;
  localparam logic [15:0] TARGET_RST      = 16'hffff;
  localparam logic [1:0]  CAUSE_RST       = 2'h1;

  typedef enum logic [2:0] {AOT_ACTIVE, AOT_IDLE, AOT_DEEP, AOT_PDOWN, AOT_WAKE} aot_state_e;

  // rc period in system clocks for a signed trim code, elaboration only
  function automatic int unsigned rc_period(input int trim);
    return CLK_HZ / (RC_NOM_HZ + trim * RC_TRIM_STEP_HZ);
  endfunction

endpackage

`default_nettype wire

/* pkg/aot_tmr_if.sv */
/*
  Link between the power controller and its sleep timer.
  Assumes both ends share one clock.
*/
`default_nettype none

interface aot_tmr_if;
  logic        cal_tick;
  logic [3:0]  presc_exp;
  logic [15:0] target;
  logic [15:0] count;
  logic        match;

  modport timer (input cal_tick, presc_exp, target, output count, match);
  modport ctrl  (output cal_tick, presc_exp, target, input count, match);
endinterface

`default_nettype wire

/* tb/aot_host_model.sv */
/*
  Host side model: drives the active-low wake pin on request.
  Assumes an internal pull-up, so a released pin reads high.
*/
`default_nettype none

module aot_host_model
(
  input  wire logic CLK,
  input  wire logic wake_req,
  output var logic  HOST_WAKE_REQUEST_N = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // pin moves just after an edge; released means pulled high
  always @(posedge CLK)
    HOST_WAKE_REQUEST_N <= !wake_req;
endmodule

`default_nettype wire

/* tb/aot_power_ctrl_sva.sv */
/*
  Port-level checker for the power controller.
  Assumes one clock and synchronous active-high RST.
*/
`default_nettype none

module aot_power_ctrl_sva
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       WB_CYC_I,
  input  wire logic       WB_STB_I,
  input  wire logic       WB_ACK_O,
  input  wire logic       HOST_WAKE_REQUEST_N,
  input  wire logic       CPU_IRQ_ANY,
  input  wire logic [7:0] FROZEN_OUT_Q,
  input  wire logic       CPU_HALT,
  input  wire logic       CORE_POWER_EN,
  input  wire logic       RADIO_POWER_EN,
  input  wire logic       REGULATOR_OUTPUT_PIN,
  input  wire logic       OUTPUT_FREEZE,
  input  wire logic       RC_CLK_TICK
);
  logic [10:0] gap_r;
  logic [10:0] gap_nxt;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // cycles since last rc tick; slowest trim gives about 1667
  assign gap_nxt = RC_CLK_TICK ? 11'h000 : gap_r + 11'h001;
  always_ff @(posedge CLK)
    gap_r <= RST ? 11'h000 : gap_nxt;

  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence asleep;
    OUTPUT_FREEZE && !REGULATOR_OUTPUT_PIN;
  endsequence
  sequence wake_up;
    ##[1:6] REGULATOR_OUTPUT_PIN;
  endsequence

  ack_follow_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not answered next cycle");
  rc_alive_a: assert property (gap_r < 11'h6a4)
    else $error("rc tick stopped");
  rc_pulse_a: assert property (RC_CLK_TICK |=> !RC_CLK_TICK [*4])
    else $error("rc ticks too close");
  sleep_power_a: assert property (OUTPUT_FREEZE |-> CPU_HALT && !CORE_POWER_EN && !RADIO_POWER_EN)
    else $error("power on while frozen");
  reg_first_a: assert property ($rose(CORE_POWER_EN) |-> $past(REGULATOR_OUTPUT_PIN))
    else $error("power back before regulator");
  freeze_hold_a: assert property (OUTPUT_FREEZE && $past(OUTPUT_FREEZE) |-> $stable(FROZEN_OUT_Q))
    else $error("frozen outputs moved");
  idle_power_a: assert property (CPU_HALT && !OUTPUT_FREEZE |-> CORE_POWER_EN && RADIO_POWER_EN
                                 && REGULATOR_OUTPUT_PIN)
    else $error("idle lost power");
  idle_exit_a: assert property (CPU_HALT && !OUTPUT_FREEZE && CPU_IRQ_ANY |-> ##[1:3] !CPU_HALT)
    else $error("idle ignored interrupt");
  host_wake_a: assert property (asleep ##0 !HOST_WAKE_REQUEST_N |-> wake_up)
    else $error("host wake ignored");
endmodule

bind aot_power_ctrl aot_power_ctrl_sva u_sva (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
  .HOST_WAKE_REQUEST_N, .CPU_IRQ_ANY, .FROZEN_OUT_Q, .CPU_HALT, .CORE_POWER_EN,
  .RADIO_POWER_EN, .REGULATOR_OUTPUT_PIN, .OUTPUT_FREEZE, .RC_CLK_TICK);

`default_nettype wire

/* tb/aot_power_ctrl_tb_top.sv */
/*
  Testbench: Wishbone tasks and directed power-mode sequences.
  Assumes the watchdog shortened to 20 rc ticks.
*/
`default_nettype none

module aot_power_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic        irq = 1'b0;
  logic [7:0]  core_d = 8'h00;
  logic        wake_req = 1'b0;
  logic [31:0] dat_r, rd;
  logic [7:0]  frz_q;
  logic        ack, wake_n, halt, core_en, radio_en, reg_pin, freeze, rc_tick, cal_tick, core_rst;
  int          bad_count = 0;
  int          compares = 0;
  int          cyc_cnt = 0;
  int          n, p, c0;

  // 10 MHz clock
  always #50 clk = ~clk;

  aot_power_ctrl #(.WDOG_TICKS(20)) uut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .HOST_WAKE_REQUEST_N(wake_n), .CPU_IRQ_ANY(irq), .CORE_OUT_D(core_d),
    .FROZEN_OUT_Q(frz_q), .CPU_HALT(halt), .CORE_POWER_EN(core_en), .RADIO_POWER_EN(radio_en),
    .REGULATOR_OUTPUT_PIN(reg_pin), .OUTPUT_FREEZE(freeze), .RC_CLK_TICK(rc_tick),
    .CAL_1K_TICK(cal_tick), .CORE_RESET(core_rst));
  aot_host_model host (.CLK(clk), .wake_req(wake_req), .HOST_WAKE_REQUEST_N(wake_n));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task give_verdict;
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task check_in(input string what, input int lo, input int hi, input logic [31:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
      bad_count++;
    end
  endtask
  // classic cycle: hold until ack is sampled, then one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check_eq(what, exp, rd);
  endtask
  task kick;
    wb(1'b1, aot_pkg::ADR_WDOG_RESTART, 32'h0);
  endtask
  // waits n cycles, restarting the watchdog every 1000
  task run(input int cycles);
    repeat (cycles / 1000)
    begin
      kick();
      repeat (1000) @(posedge clk);
    end
  endtask
  // cycles between two consecutive ticks
  task tick_gap(input bit use_cal, output int g);
    kick();
    do @(posedge clk); while ((use_cal ? cal_tick : rc_tick) !== 1'b1);
    g = 0;
    do
    begin
      @(posedge clk);
      g++;
    end
    while ((use_cal ? cal_tick : rc_tick) !== 1'b1);
  endtask
  task wait_hi(input int lim, output int k);
    k = 0;
    while (k < lim && (reg_pin !== 1'b1 || k == 0))
    begin
      @(posedge clk);
      k++;
    end
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 90000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("div", aot_pkg::ADR_CAL_DIV, 32'h0000000a);
    rd_chk("prescale", aot_pkg::ADR_PRESCALE, 32'h0);
    rd_chk("target", aot_pkg::ADR_WAKE_TARGET, 32'h0000ffff);
    rd_chk("cause", aot_pkg::ADR_RESET_CAUSE, 32'h1);
    rd_chk("unmapped", 8'h40, 32'h0);
    wb(1'b1, aot_pkg::ADR_RC_TRIM, 32'h1);
    tick_gap(1'b0, p);
    check_in("rc up", 908, 910, p);
    wb(1'b1, aot_pkg::ADR_RC_TRIM, 32'h7);
    tick_gap(1'b0, p);
    check_in("rc down", 1110, 1112, p);
    wb(1'b1, aot_pkg::ADR_RC_TRIM, 32'h0);
    wb(1'b1, aot_pkg::ADR_CAL_DIV, 32'h2);
    tick_gap(1'b1, p);
    check_in("cal", 1999, 2001, p);
    wb(1'b1, aot_pkg::ADR_CAL_DIV, 32'h1);
    wb(1'b1, aot_pkg::ADR_PRESCALE, 32'h1);
    rd_chk("div", aot_pkg::ADR_CAL_DIV, 32'h1);
    wb(1'b0, aot_pkg::ADR_SLEEP_COUNT, 32'h0);
    c0 = int'(rd[15:0]);
    run(8000);
    wb(1'b0, aot_pkg::ADR_SLEEP_COUNT, 32'h0);
    check_in("ms ticks", 3, 5, {16'h0, rd[15:0] - 16'(c0)});
    wb(1'b1, aot_pkg::ADR_PRESCALE, 32'h0);
    wb(1'b1, aot_pkg::ADR_POWER_CMD, {30'h0, aot_pkg::CMD_IDLE});
    check_eq("idle outs", 32'hf, {28'h0, halt, core_en, radio_en, reg_pin});
    irq <= 1'b1;
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    check_eq("idle exit", 32'h0, {31'h0, halt});
    run(1000);
    core_d <= 8'h5a;
    wb(1'b0, aot_pkg::ADR_SLEEP_COUNT, 32'h0);
    wb(1'b1, aot_pkg::ADR_WAKE_TARGET, {16'h0, rd[15:0] + 16'h0003});
    wb(1'b1, aot_pkg::ADR_POWER_CMD, {30'h0, aot_pkg::CMD_DEEP});
    rd_chk("deep", aot_pkg::ADR_POWER_CMD, 32'h2);
    check_eq("deep outs", 32'h11, {27'h0, halt, core_en, radio_en, reg_pin, freeze});
    core_d <= 8'ha5;
    repeat (5) @(posedge clk);
    check_eq("frozen", 32'h5a, {24'h0, frz_q});
    wait_hi(6000, n);
    check_in("timer wake", 1, 5999, n);
    rd_chk("match", aot_pkg::ADR_STATUS, 32'h1);
    repeat (600) @(posedge clk);
    check_eq("awake", 32'h2, {30'h0, core_en, freeze});
    wb(1'b1, aot_pkg::ADR_STATUS, 32'h3);
    run(1000);
    wb(1'b0, aot_pkg::ADR_SLEEP_COUNT, 32'h0);
    wb(1'b1, aot_pkg::ADR_WAKE_TARGET, {16'h0, rd[15:0] + 16'h0002});
    wb(1'b1, aot_pkg::ADR_POWER_CMD, {30'h0, aot_pkg::CMD_PDOWN});
    rd_chk("pdown", aot_pkg::ADR_POWER_CMD, 32'h3);
    repeat (5000) @(posedge clk);
    check_eq("no timer wake", 32'h0, {31'h0, reg_pin});
    wake_req <= 1'b1;
    wait_hi(10, n);
    check_in("host wake", 1, 9, n);
    rd_chk("host edge", aot_pkg::ADR_STATUS, 32'h3);
    wake_req <= 1'b0;
    repeat (600) @(posedge clk);
    rd_chk("active", aot_pkg::ADR_POWER_CMD, 32'h0);
    kick();
    wb(1'b0, aot_pkg::ADR_WDOG_RESTART, 32'h0);
    check_in("wd restart", 0, 1, rd);
    n = 0;
    while (core_rst !== 1'b1 && n < 25000)
    begin
      @(posedge clk);
      n++;
    end
    check_in("watchdog", 18900, 20100, n);
    repeat (20) @(posedge clk);
    rd_chk("wd cause", aot_pkg::ADR_RESET_CAUSE, 32'h2);
    give_verdict();
  end
endmodule

`default_nettype wire
